/* File: core/dbr_top.sv */
/*
 * four-channel transfer controller: registers, request handling, bus ownership,
 * acknowledge timing, nmi and address-error halt, end interrupts.
 * assumes request and nmi pins are asynchronous; addr_err, int_req and
 * long_cycle come from logic on ref_clk.
 */
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module dbr_top #(
    parameter int NCH = 4
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [dbr_pkg::AW-1:0] reg_addr,
    input wire logic [dbr_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dbr_pkg::DW-1:0] reg_rdata,
    input wire logic [NCH-1:0] transfer_request_pin_n,
    input wire logic [NCH-1:0] int_req,
    input wire logic nmi_pin,
    input wire logic addr_err,
    input wire logic long_cycle,
    output logic bus_own,
    output logic [NCH-1:0] transfer_acknowledge_pin_n,
    output logic [NCH-1:0] transfer_end_interrupt,
    output logic irq
);
    dbr_pkg::dbr_state_t state;
    logic [2:0] st, last_st, ack_st;
    logic [1:0] act, gnt, wch;
    logic op_en, op_nmi, op_ae;
    logic [NCH-1:0] ctl_en, ctl_te, ctl_ie, ctl_burst, ctl_edge, ctl_pin;
    logic [dbr_pkg::SRC_W-1:0] ctl_src [NCH];
    logic [dbr_pkg::CNT_W-1:0] cnt_act, cnt [NCH];
    logic [dbr_pkg::DW-1:0] ctl_word [NCH];
    logic [NCH-1:0] pin_lvl, pin_fall, req_lvl, req_pend, elig, done_ch;
    logic [dbr_pkg::STAT_W-1:0] stat, mask, next_stat;
    logic [dbr_pkg::DW-1:0] next_rdata;
    logic nmi_s1, nmi_s2, nmi_s3, nmi_rise;
    logic gnt_v, halt, abort, start, last, done, word_ok;
    logic [3:0] pg;

    assign pg = reg_addr[7:4];
    assign wch = reg_addr[3:2];
    assign word_ok = reg_addr[1:0] == 2'h0;
    assign halt = op_nmi | op_ae;
    assign cnt_act = cnt[act];
    assign nmi_rise = nmi_s2 & ~nmi_s3;
    assign last_st = long_cycle ? dbr_pkg::ST_LAST_LONG : dbr_pkg::ST_LAST;
    assign ack_st = long_cycle ? dbr_pkg::ST_ACK_LONG : dbr_pkg::ST_ACK;
    assign abort = state == dbr_pkg::S_XFER && (halt || !op_en || !ctl_en[act]);
    assign last = state == dbr_pkg::S_XFER && !abort && st == last_st;
    assign done = last && cnt_act == dbr_pkg::CNT_ONE;
    assign start = state == dbr_pkg::S_IDLE && op_en && !halt && gnt_v;

    // nmi pin synchroniser; the rise is taken between the second and third stages
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            nmi_s1 <= 1'b0;
            nmi_s2 <= 1'b0;
            nmi_s3 <= 1'b0;
        end
        else if (clk_en)
        begin
            nmi_s1 <= nmi_pin;
            nmi_s2 <= nmi_s1;
            nmi_s3 <= nmi_s2;
        end
    end

    // operation register; hardware set wins over a software clear
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            op_en <= 1'b0;
            op_nmi <= 1'b0;
            op_ae <= 1'b0;
        end
        else if (clk_en)
        begin
            if (reg_wr && reg_addr == dbr_pkg::OFS_OP)
            begin
                op_en <= reg_wdata[dbr_pkg::OP_EN];
                op_nmi <= op_nmi & reg_wdata[dbr_pkg::OP_NMI];
                op_ae <= op_ae & reg_wdata[dbr_pkg::OP_AE];
            end
            if (nmi_rise)
                op_nmi <= 1'b1;
            if (addr_err)
                op_ae <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NCH; i++)
        begin : g_ch
            logic wr_ctl;
            logic wr_cnt;
            logic ev;
            logic taken;
            assign wr_ctl = reg_wr && pg == dbr_pkg::PG_CTL && word_ok && wch == i;
            assign wr_cnt = reg_wr && pg == dbr_pkg::PG_CNT && word_ok && wch == i;
            assign done_ch[i] = done && act == i;
            assign taken = start && gnt == i;
            dbr_req_detect u_det (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .clk_en(clk_en),
                .pin_n(transfer_request_pin_n[i]),
                .pin_sel(ctl_pin[i]),
                .req_lvl(pin_lvl[i]),
                .req_fall(pin_fall[i])
            );
            assign req_lvl[i] = ctl_src[i] == dbr_pkg::SRC_PIN ? pin_lvl[i] : int_req[i];
            assign ev = ctl_src[i] == dbr_pkg::SRC_PIN ? pin_fall[i] : int_req[i];
            assign elig[i] = ctl_en[i] & ~ctl_te[i] & req_pend[i] & (cnt[i] != '0);
            always_comb
            begin
                ctl_word[i] = '0;
                ctl_word[i][dbr_pkg::CTL_EN] = ctl_en[i];
                ctl_word[i][dbr_pkg::CTL_TE] = ctl_te[i];
                ctl_word[i][dbr_pkg::CTL_IE] = ctl_ie[i];
                ctl_word[i][dbr_pkg::CTL_BURST] = ctl_burst[i];
                ctl_word[i][dbr_pkg::CTL_EDGE] = ctl_edge[i];
                ctl_word[i][dbr_pkg::CTL_PIN] = ctl_pin[i];
                ctl_word[i][dbr_pkg::CTL_SRC +: dbr_pkg::SRC_W] = ctl_src[i];
            end
            always_ff @(posedge ref_clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    ctl_en[i] <= 1'b0;
                    ctl_te[i] <= 1'b0;
                    ctl_ie[i] <= 1'b0;
                    ctl_burst[i] <= 1'b0;
                    ctl_edge[i] <= 1'b0;
                    ctl_pin[i] <= 1'b0;
                    ctl_src[i] <= dbr_pkg::SRC_PIN;
                end
                else if (clk_en)
                begin
                    if (wr_ctl)
                    begin
                        ctl_en[i] <= reg_wdata[dbr_pkg::CTL_EN];
                        ctl_te[i] <= ctl_te[i] & reg_wdata[dbr_pkg::CTL_TE];
                        ctl_ie[i] <= reg_wdata[dbr_pkg::CTL_IE];
                        ctl_burst[i] <= reg_wdata[dbr_pkg::CTL_BURST];
                        ctl_edge[i] <= reg_wdata[dbr_pkg::CTL_EDGE];
                        ctl_pin[i] <= reg_wdata[dbr_pkg::CTL_PIN];
                        ctl_src[i] <= reg_wdata[dbr_pkg::CTL_SRC +: dbr_pkg::SRC_W];
                    end
                    if (done_ch[i])
                        ctl_te[i] <= 1'b1;
                end
            end
            // software load wins over the decrement of the same cycle
            always_ff @(posedge ref_clk or posedge sys_rst)
            begin
                if (sys_rst)
                    cnt[i] <= '0;
                else if (clk_en)
                begin
                    if (wr_cnt)
                        cnt[i] <= reg_wdata[dbr_pkg::CNT_W-1:0];
                    else if (last && act == i)
                        cnt[i] <= cnt[i] - dbr_pkg::CNT_ONE;
                end
            end
            always_ff @(posedge ref_clk or posedge sys_rst)
            begin
                if (sys_rst)
                    req_pend[i] <= 1'b0;
                else if (clk_en)
                begin
                    if (ctl_edge[i])
                        req_pend[i] <= (req_pend[i] & ~taken) | ev;
                    else if (state == dbr_pkg::S_XFER && act == i)
                    begin
                        if (st == dbr_pkg::ST_SAMPLE)
                            req_pend[i] <= req_lvl[i];
                    end
                    else
                        req_pend[i] <= req_lvl[i];
                end
            end
            always_ff @(posedge ref_clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    transfer_acknowledge_pin_n[i] <= 1'b1;
                    transfer_end_interrupt[i] <= 1'b0;
                end
                else if (clk_en)
                begin
                    // acknowledge after sample, gone with the bus
                    transfer_acknowledge_pin_n[i] <= ~(state == dbr_pkg::S_XFER && !abort
                        && act == i && st >= ack_st && st != last_st);
                    transfer_end_interrupt[i] <= ctl_te[i] & ctl_ie[i];
                end
            end
        end
    endgenerate

    dbr_prio_arb u_arb (
        .elig(elig),
        .gnt_v(gnt_v),
        .gnt(gnt)
    );

    // bus ownership sequencer
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= dbr_pkg::S_IDLE;
            st <= '0;
            act <= '0;
            bus_own <= 1'b0;
        end
        else if (clk_en)
        begin
            unique case (state)
                dbr_pkg::S_IDLE:
                begin
                    if (start)
                    begin
                        state <= dbr_pkg::S_XFER;
                        act <= gnt;
                        st <= '0;
                        bus_own <= 1'b1;
                    end
                end
                dbr_pkg::S_XFER:
                begin
                    if (abort)
                    begin
                        state <= dbr_pkg::S_REL;
                        bus_own <= 1'b0;
                    end
                    else if (st == last_st)
                    begin
                        st <= '0;
                        if (ctl_burst[act] && !done && (ctl_edge[act] || req_lvl[act]))
                            state <= dbr_pkg::S_XFER;
                        else
                        begin
                            state <= dbr_pkg::S_REL;
                            bus_own <= 1'b0;
                        end
                    end
                    else
                        st <= st + 3'h1;
                end
                dbr_pkg::S_REL:
                    state <= dbr_pkg::S_IDLE;
            endcase
        end
    end

    // status is sticky; a read clears it but a new event in that cycle survives
    always_comb
    begin
        next_stat = stat;
        if (reg_rd && reg_addr == dbr_pkg::OFS_STAT)
            next_stat = '0;
        next_stat[NCH-1:0] = next_stat[NCH-1:0] | done_ch;
        next_stat[dbr_pkg::STAT_NMI] = next_stat[dbr_pkg::STAT_NMI] | nmi_rise;
        next_stat[dbr_pkg::STAT_AE] = next_stat[dbr_pkg::STAT_AE] | addr_err;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stat <= '0;
            mask <= '0;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            stat <= next_stat;
            if (reg_wr && reg_addr == dbr_pkg::OFS_MASK)
                mask <= reg_wdata[dbr_pkg::STAT_W-1:0];
            irq <= |(next_stat & mask);
        end
    end

    always_comb
    begin
        next_rdata = '0;
        if (reg_addr == dbr_pkg::OFS_OP)
        begin
            next_rdata[dbr_pkg::OP_EN] = op_en;
            next_rdata[dbr_pkg::OP_NMI] = op_nmi;
            next_rdata[dbr_pkg::OP_AE] = op_ae;
        end
        else if (pg == dbr_pkg::PG_CTL && word_ok)
            next_rdata = ctl_word[wch];
        else if (pg == dbr_pkg::PG_CNT && word_ok)
            next_rdata[dbr_pkg::CNT_W-1:0] = cnt[wch];
        else if (reg_addr == dbr_pkg::OFS_STAT)
            next_rdata[dbr_pkg::STAT_W-1:0] = stat;
        else if (reg_addr == dbr_pkg::OFS_MASK)
            next_rdata[dbr_pkg::STAT_W-1:0] = mask;
        else if (reg_addr == dbr_pkg::OFS_STATE)
            next_rdata[5:0] = {act, state, bus_own};
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (clk_en)
            reg_rdata <= reg_rd ? next_rdata : '0;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_nmi_flag_set: assert property (nmi_rise && clk_en |=> op_nmi)
        else $error("nmi did not set stop flag");
    a_nmi_bus_drop: assert property (state == dbr_pkg::S_XFER && op_nmi && clk_en
        |=> !bus_own && state == dbr_pkg::S_REL)
        else $error("bus kept after nmi");
    a_burst_hold: assert property (last && ctl_burst[act] && ctl_edge[act] && !done && clk_en
        |=> bus_own && state == dbr_pkg::S_XFER && st == '0)
        else $error("burst released bus early");
    a_steal_release: assert property (last && !ctl_burst[act] && clk_en
        |=> !bus_own ##1 state != dbr_pkg::S_XFER)
        else $error("cycle steal kept bus");
    a_ack_after_smp: assert property (state == dbr_pkg::S_XFER && st == dbr_pkg::ST_SAMPLE
        |-> &transfer_acknowledge_pin_n)
        else $error("acknowledge before sample point");
    a_ack_long_late: assert property (state == dbr_pkg::S_XFER && long_cycle && clk_en
        && st == dbr_pkg::ST_LAST |=> &transfer_acknowledge_pin_n)
        else $error("acknowledge early on long cycle");
    a_prio_fixed: assert property (gnt_v |-> gnt == (elig[0] ? 2'h0 : elig[3] ? 2'h3
        : elig[2] ? 2'h2 : 2'h1))
        else $error("priority order broken");
    a_end_flag: assert property (done && clk_en |=> ctl_te[$past(act)])
        else $error("end flag not set");
    a_halt_no_te: assert property (state == dbr_pkg::S_XFER && halt && clk_en
        |=> ctl_te == $past(ctl_te) && !bus_own)
        else $error("halt set end flag or kept bus");
    a_count_dec: assert property (last && !reg_wr && clk_en
        |=> cnt[$past(act)] == $past(cnt_act) - dbr_pkg::CNT_ONE)
        else $error("count not decremented");

    c_burst_done: cover property (done && ctl_burst[act]);
    c_steal_unit: cover property (last && !ctl_burst[act] ##2 start);
    c_nmi_abort: cover property (state == dbr_pkg::S_XFER && op_nmi);
endmodule : dbr_top
`default_nettype wire

/* File: core/dbr_pkg.sv */
/*
 * constants, register map and state type of the four-channel transfer controller.
 * assumes a plain word-wide register port on the system clock.
 */
// Overview of operation
// - the nmi stop flag is set on every nmi, even when idle.
// - an nmi during a transfer halts it and hands the bus back.
// - burst mode keeps the bus until the run completes with edge requests, or while a level request holds, ignoring ordinary interrupts.
// - cycle-steal mode releases the bus after every single transfer unit.
// - level requests in cycle steal are sampled in the third state.
// - long or refresh cycles delay the acknowledge past the sample point.
// - switching a low general input to request function gives a falling edge.
// - the count register holds a plain binary number of transfer units.
// - fixed priority arbitrates channel 0, then 3, then 2, then 1.
// - count reaching zero sets the transfer-end flag and, if enabled, interrupts.
// - nmi or address error halt all channels without setting transfer-end flags.
package dbr_pkg;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int CNT_W = 16;
    localparam int SRC_W = 4;
    localparam logic [AW-1:0] OFS_OP = 8'h00;
    localparam logic [AW-1:0] OFS_STAT = 8'h30;
    localparam logic [AW-1:0] OFS_MASK = 8'h34;
    localparam logic [AW-1:0] OFS_STATE = 8'h38;
    localparam logic [3:0] PG_CTL = 4'h1;
    localparam logic [3:0] PG_CNT = 4'h2;
    localparam int OP_EN = 0;
    localparam int OP_NMI = 1;
    localparam int OP_AE = 2;
    localparam int CTL_EN = 0;
    localparam int CTL_TE = 1;
    localparam int CTL_IE = 2;
    localparam int CTL_BURST = 3;
    localparam int CTL_EDGE = 4;
    localparam int CTL_PIN = 5;
    localparam int CTL_SRC = 8;
    localparam logic [SRC_W-1:0] SRC_PIN = 4'h0;
    localparam int STAT_NMI = 4;
    localparam int STAT_AE = 5;
    localparam int STAT_W = 6;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    // state indices inside one transfer unit, counted from zero
    localparam logic [2:0] ST_SAMPLE = 3'h2;
    localparam logic [2:0] ST_ACK = 3'h2;
    localparam logic [2:0] ST_ACK_LONG = 3'h4;
    localparam logic [2:0] ST_LAST = 3'h3;
    localparam logic [2:0] ST_LAST_LONG = 3'h5;
    // fixed order 0, 3, 2, 1, listed from the low pair up; the arbiter lets the low pair win
    localparam logic [7:0] PRIO_ORDER = 8'h6c;
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_XFER = 3'b010,
        S_REL = 3'b100
    } dbr_state_t;
endpackage : dbr_pkg

/* File: core/dbr_req_detect.sv */
/*
 * request pin synchroniser with level and falling-edge detection.
 * assumes an asynchronous active-low pin and a same-clock pin function select.
 */
`timescale 1ns/1ns
`default_nettype none
module dbr_req_detect (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic pin_n,
    input wire logic pin_sel,
    output logic req_lvl,
    output logic req_fall
);
    logic s1;
    logic s2;
    logic prev;
    logic eff;
    // a general input reads as idle high; a low pin switched in looks like a falling edge
    // edge on function switch
    assign eff = pin_sel ? s2 : 1'b1;
    assign req_lvl = ~eff;
    assign req_fall = prev & ~eff;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            prev <= 1'b1;
        end
        else if (clk_en)
        begin
            s1 <= pin_n;
            s2 <= s1;
            prev <= eff;
        end
    end
endmodule : dbr_req_detect
`default_nettype wire

/* File: core/dbr_prio_arb.sv */
/*
 * fixed-priority channel arbiter, combinational.
 * assumes one eligibility bit per channel from the same clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
module dbr_prio_arb (
    input wire logic [3:0] elig,
    output logic gnt_v,
    output logic [1:0] gnt
);
    logic [1:0] ch;
    always_comb
    begin
        ch = 2'h0;
        gnt_v = 1'b0;
        gnt = 2'h0;
        for (int k = 3; k >= 0; k--)
        begin
            ch = dbr_pkg::PRIO_ORDER[2*k +: 2];
            if (elig[ch])
            begin
                gnt_v = 1'b1;
                gnt = ch;
            end
        end
    end
endmodule : dbr_prio_arb
`default_nettype wire

/* File: testbench/dbr_periph.sv */
/*
 * peripheral model on the request pin of channel 0.
 * assumes an active-low acknowledge from the controller on ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module dbr_periph (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic edge_mode,
    input wire logic ack_n,
    output var logic req_n = 1'b1
);
    always @(posedge ref_clk)
    begin
        req_n <= ~go | (edge_mode & ~ack_n);
    end
endmodule : dbr_periph
`default_nettype wire

/* File: testbench/dbr_top_tb.sv */
/*
 * self-checking bench of the transfer controller.
 * assumes the word register port and one request peripheral on channel 0.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module dbr_top_tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [dbr_pkg::AW-1:0] reg_addr = '0;
    logic [dbr_pkg::DW-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [dbr_pkg::DW-1:0] reg_rdata;
    logic [3:0] int_req = 4'h0;
    logic nmi_pin = 1'b0;
    logic addr_err = 1'b0;
    logic long_cycle = 1'b0;
    logic go = 1'b0;
    logic edge_mode = 1'b0;
    logic req0_n;
    logic bus_own;
    logic [3:0] ack_n;
    logic [3:0] tei;
    logic irq;
    logic [31:0] rv;
    int err_total = 0;
    int samples_checked = 0;
    always #2 ref_clk = ~ref_clk;
    dbr_top u_dut (.ref_clk, .sys_rst, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .transfer_request_pin_n({3'h7, req0_n}), .int_req, .nmi_pin, .addr_err,
        .long_cycle, .bus_own, .transfer_acknowledge_pin_n(ack_n), .transfer_end_interrupt(tei), .irq);
    dbr_periph u_periph (.ref_clk, .go, .edge_mode, .ack_n(ack_n[0]), .req_n(req0_n));
    task automatic results;
        $display("mismatches %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask : rd
    // a hang here ends the run at once
    task automatic wait_own(input logic v);
        int i;
        for (i = 0; i < 300 && bus_own !== v; i++)
            step();
        if (bus_own !== v)
        begin
            err_total++;
            results();
        end
    endtask : wait_own
    task automatic t_regs;
        wr(8'h20, 32'h40);
        rd(8'h20);
        `CHK(rv, 32'h40)
        rd(8'h3c);
        `CHK(rv, 32'h0)
    endtask : t_regs
    task automatic t_xfer(input logic [15:0] n, input logic lng);
        int k;
        int c;
        wr(8'h20, {16'h0, n});
        wr(8'h10, 32'h25); // pin still high at switch
        long_cycle <= lng;
        go <= 1'b1;
        for (k = 0; k < n; k++)
        begin
            wait_own(1'b1);
            c = 0;
            while (ack_n[0] !== 1'b0 && c < 20)
            begin
                step();
                c++;
            end
            `CHK(c, lng ? 5 : 3)
            wait_own(1'b0);
        end
        @(posedge ref_clk);
        go <= 1'b0;
        long_cycle <= 1'b0;
        rd(8'h20);
        `CHK(rv, 32'h0)
        rd(8'h10); // poll end flag
        `CHK(rv[1], 1'b1)
        `CHK(tei[0], 1'b1)
        `CHK(irq, 1'b0)
        wr(8'h10, 32'h0); // stop channel
    endtask : t_xfer
    task automatic t_prio;
        int ord[4] = '{0, 3, 2, 1};
        int k;
        int c;
        for (k = 0; k < 4; k++)
        begin
            wr(8'h20 + 8'(4 * k), 32'h1);
            wr(8'h10 + 8'(4 * k), 32'h111); // end flag already clear
        end
        @(posedge ref_clk);
        int_req <= 4'hf;
        @(posedge ref_clk);
        int_req <= 4'h0;
        for (k = 0; k < 4; k++)
        begin
            c = 0;
            while (ack_n === 4'hf && c < 100)
            begin
                step();
                c++;
            end
            `CHK(ack_n, 4'hf ^ (4'h1 << ord[k]))
            wait_own(1'b0);
        end
        for (k = 0; k < 4; k++)
            wr(8'h10 + 8'(4 * k), 32'h0);
    endtask : t_prio
    task automatic t_pin;
        wr(8'h20, 32'h1);
        edge_mode <= 1'b1;
        go <= 1'b1;
        wr(8'h10, 32'h15);
        repeat (10) step();
        `CHK(bus_own, 1'b0)
        wr(8'h10, 32'h35);
        wait_own(1'b1);
        wait_own(1'b0);
        go <= 1'b0;
        edge_mode <= 1'b0;
        wr(8'h10, 32'h0);
    endtask : t_pin
    task automatic t_burst;
        int c;
        wr(8'h20, 32'h40);
        wr(8'h10, 32'h3d);
        edge_mode <= 1'b1;
        go <= 1'b1;
        wait_own(1'b1);
        c = 0;
        repeat (24)
        begin
            step();
            c += int'(bus_own === 1'b1);
        end
        `CHK(c, 24)
        @(posedge ref_clk);
        nmi_pin <= 1'b1;
        c = 0;
        while (bus_own === 1'b1 && c < 20)
        begin
            step();
            c++;
        end
        `CHK(bus_own, 1'b0)
        @(posedge ref_clk);
        nmi_pin <= 1'b0;
        go <= 1'b0;
        edge_mode <= 1'b0;
        rd(8'h10);
        `CHK(rv[1], 1'b0)
        rd(8'h20);
        `CHK(rv[15:0] != 16'h0, 1'b1)
        wr(8'h10, 32'h0);
    endtask : t_burst
    task automatic t_nmi;
        // flag left over from the burst abort is cleared so the idle set is really seen
        wr(8'h00, 32'h1);
        rd(8'h30);
        wr(8'h34, 32'h10);
        nmi_pin <= 1'b1;
        repeat (8) step();
        `CHK(irq, 1'b1)
        rd(8'h00);
        `CHK(rv[1], 1'b1)
        rd(8'h30);
        `CHK(rv, 32'h10)
        rd(8'h30);
        `CHK(rv, 32'h0)
        `CHK(irq, 1'b0)
        @(posedge ref_clk);
        nmi_pin <= 1'b0;
        addr_err <= 1'b1;
        @(posedge ref_clk);
        addr_err <= 1'b0;
        rd(8'h00);
        `CHK(rv[2:1], 2'h3)
        wr(8'h00, 32'h1);
        rd(8'h00);
        `CHK(rv, 32'h1)
    endtask : t_nmi
    initial
    begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wr(8'h00, 32'h1);
        t_regs();
        t_xfer(16'h2, 1'b0);
        t_xfer(16'h1, 1'b1);
        t_prio();
        t_pin();
        t_burst();
        t_nmi();
        results();
    end
endmodule : dbr_top_tb
`default_nettype wire
